// ### hdl/rtcc_card_ctrl.sv
// Operation
// RULE1 - unreturned retry sets expiry flag after 2^15 clocks
// RULE2 - expiry flags clear only on written one
// RULE3 - retry bit 7 enables primary counter
// RULE4 - retry bit 6 enables card-bus counters, shared
// RULE5 - retry bit 5 flags target b expiry
// RULE6 - retry bit 3 flags target a expiry, shared
// RULE7 - retry bit 1 flags primary target expiry
// RULE8 - retry bits 4, 2, 0 read zero
// RULE9 - shared bits live once, written through function 0
// RULE10 - ring enable gates all ring indicate routing
// RULE11 - video mode enable floats that socket's video port
// RULE12 - port select picks priority with both in video
// RULE13 - card bits 4 and 3 read zero
// RULE14 - audio enable routes card audio, socket 0 wins
// RULE15 - speaker pin is xor of enabled speakers
// RULE16 - speaker pin driven only while any enabled
// RULE17 - functional interrupt sets flag, written one clears
// RULE18 - card control resets to all zeros
// RULE19 - retry starts timer, new retry restarts, return stops
`timescale 1ns/10ps
`include "rtcc_map.svh"
module rtcc_card_ctrl
    import rtcc_pkg::*;
(
    // clock and reset
    input  wire logic       i_clock,
    input  wire logic       i_reset,
    // configuration access, function 0 or 1
    input  wire rtcc_cfg_s  i_cfg,
    output logic [7:0]      o_rdata,
    // retry side events
    input  wire logic       i_primary_retried,
    input  wire logic       i_primary_returned,
    input  wire logic [1:0] i_cardbus_retried,
    input  wire logic [1:0] i_cardbus_returned,
    // socket side
    input  wire logic [1:0] i_card_functional_irq,
    input  wire logic [1:0] i_card_speaker_signal,
    input  wire logic [1:0] i_card_audio_signal,
    input  wire logic       i_ring_indicate,
    input  wire logic       i_ring_pin_mux_select,
    input  wire logic       i_multifunction_terminal_two_is_ring,
    input  wire logic       i_multifunction_terminal_four_is_ring,
    // pins
    output logic            o_ring_indicate_output,
    output logic            o_multifunction_terminal_two,
    output logic            o_multifunction_terminal_four,
    output logic            o_audio_output_route_code,
    output logic            o_speaker_output_pin,
    output logic            o_speaker_output_pin_oe,
    output logic [1:0]      o_video_port_hiz,
    output logic            o_video_select_socket0,
    output logic            o_video_select_socket1
);
    localparam logic [7:0] RETRY_RESET = `RTCC_RETRY_RESET;
    logic        pri_en_ff;
    logic        nxt_pri_en;
    logic        cb_en_ff;
    logic        nxt_cb_en;
    logic        exp_pri_ff;
    logic        nxt_exp_pri;
    logic        exp_a_ff;
    logic        nxt_exp_a;
    logic        exp_b_ff;
    logic        nxt_exp_b;
    logic        ring_en_ff;
    logic        nxt_ring_en;
    rtcc_sock_s  sock_ff [2];
    rtcc_sock_s  nxt_sock [2];
    logic [7:0]  rdata_ff;
    logic [7:0]  nxt_rdata;
    logic        ev_pri;
    logic [1:0]  ev_cb;
    logic        wr_retry;
    logic        wr_card;

    function automatic logic hit(input rtcc_cfg_s c, input logic [7:0] off);
        hit = c.wr && (c.addr == off);
    endfunction : hit

    function automatic logic rd_hit(input rtcc_cfg_s c, input logic [7:0] off);
        rd_hit = c.rd && (c.addr == off);
    endfunction : rd_hit

    // a socket owns the card control copy of the function that addresses it
    function automatic logic owns(input rtcc_cfg_s c, input int s);
        owns = (c.func == s[0]);
    endfunction : owns

    // one timer per target; counter enables gate them directly
    rtcc_retry_timer u_pri (
        .i_clock   (i_clock),
        .i_reset   (i_reset),
        .i_enable  (pri_en_ff), // RULE3
        .i_retried (i_primary_retried),
        .i_returned(i_primary_returned),
        .o_expire  (ev_pri)
    );
    rtcc_retry_timer u_cba (
        .i_clock   (i_clock),
        .i_reset   (i_reset),
        .i_enable  (cb_en_ff), // RULE4
        .i_retried (i_cardbus_retried[0]),
        .i_returned(i_cardbus_returned[0]),
        .o_expire  (ev_cb[0])
    );
    rtcc_retry_timer u_cbb (
        .i_clock   (i_clock),
        .i_reset   (i_reset),
        .i_enable  (cb_en_ff), // RULE4
        .i_retried (i_cardbus_retried[1]),
        .i_returned(i_cardbus_returned[1]),
        .o_expire  (ev_cb[1])
    );

    // retry register lives in function 0 only; function 1 writes are dropped
    assign wr_retry = hit(i_cfg, `RTCC_OFF_RETRY) && !i_cfg.func; // RULE9
    assign wr_card  = hit(i_cfg, `RTCC_OFF_CARD);

    always_comb
    begin
        nxt_pri_en  = pri_en_ff;
        nxt_cb_en   = cb_en_ff;
        nxt_ring_en = ring_en_ff;
        nxt_sock    = sock_ff;
        if (wr_retry)
        begin
            nxt_pri_en = i_cfg.wdata[`RTCC_BIT_PRI_EN]; // RULE3
            nxt_cb_en  = i_cfg.wdata[`RTCC_BIT_CB_EN]; // RULE4
        end
        // set wins over write-one-to-clear
        nxt_exp_pri = ev_pri | (exp_pri_ff & !(wr_retry & i_cfg.wdata[`RTCC_BIT_EXP_PRI])); // RULE7 RULE2
        nxt_exp_a   = ev_cb[0] | (exp_a_ff & !(wr_retry & i_cfg.wdata[`RTCC_BIT_EXP_A])); // RULE6 RULE2
        nxt_exp_b   = ev_cb[1] | (exp_b_ff & !(wr_retry & i_cfg.wdata[`RTCC_BIT_EXP_B])); // RULE5 RULE2
        if (wr_card && !i_cfg.func)
            nxt_ring_en = i_cfg.wdata[`RTCC_BIT_RING_EN]; // RULE9 RULE10
        for (int s = 0; s < 2; s++)
        begin
            if (wr_card && owns(i_cfg, s))
            begin
                nxt_sock[s].video_en = i_cfg.wdata[`RTCC_BIT_VIDEO_EN]; // RULE11
                nxt_sock[s].port_sel = i_cfg.wdata[`RTCC_BIT_PORT_SEL]; // RULE12
                nxt_sock[s].audio_en = i_cfg.wdata[`RTCC_BIT_AUDIO_EN]; // RULE14
                nxt_sock[s].card_speaker_signal_en  = i_cfg.wdata[`RTCC_BIT_CARD_SPEAKER_SIGNAL_EN]; // RULE15
            end
            nxt_sock[s].irq_flag = i_card_functional_irq[s] | (sock_ff[s].irq_flag & // RULE17
                !(wr_card && owns(i_cfg, s) && i_cfg.wdata[`RTCC_BIT_IRQ_FLAG]));
        end
        nxt_rdata = 8'h00; // RULE8 RULE13
        if (rd_hit(i_cfg, `RTCC_OFF_RETRY))
        begin
            nxt_rdata[`RTCC_BIT_PRI_EN]  = pri_en_ff;
            nxt_rdata[`RTCC_BIT_CB_EN]   = cb_en_ff;
            nxt_rdata[`RTCC_BIT_EXP_B]   = exp_b_ff;
            nxt_rdata[`RTCC_BIT_EXP_A]   = exp_a_ff;
            nxt_rdata[`RTCC_BIT_EXP_PRI] = exp_pri_ff;
        end
        else if (rd_hit(i_cfg, `RTCC_OFF_CARD))
        begin
            nxt_rdata[`RTCC_BIT_RING_EN]  = ring_en_ff;
            nxt_rdata[`RTCC_BIT_VIDEO_EN] = sock_ff[i_cfg.func].video_en;
            nxt_rdata[`RTCC_BIT_PORT_SEL] = sock_ff[i_cfg.func].port_sel;
            nxt_rdata[`RTCC_BIT_AUDIO_EN] = sock_ff[i_cfg.func].audio_en;
            nxt_rdata[`RTCC_BIT_CARD_SPEAKER_SIGNAL_EN]  = sock_ff[i_cfg.func].card_speaker_signal_en;
            nxt_rdata[`RTCC_BIT_IRQ_FLAG] = sock_ff[i_cfg.func].irq_flag;
        end
    end

    always_ff @(posedge i_clock)
    begin
        if (i_reset)
        begin
            pri_en_ff  <= RETRY_RESET[`RTCC_BIT_PRI_EN]; // RULE3
            cb_en_ff   <= RETRY_RESET[`RTCC_BIT_CB_EN]; // RULE4
            exp_pri_ff <= 1'b0;
            exp_a_ff   <= 1'b0;
            exp_b_ff   <= 1'b0;
            ring_en_ff <= 1'b0; // RULE18
            sock_ff[0] <= '0;
            sock_ff[1] <= '0;
            rdata_ff   <= 8'h00;
        end
        else
        begin
            pri_en_ff  <= nxt_pri_en;
            cb_en_ff   <= nxt_cb_en;
            exp_pri_ff <= nxt_exp_pri;
            exp_a_ff   <= nxt_exp_a;
            exp_b_ff   <= nxt_exp_b;
            ring_en_ff <= nxt_ring_en;
            sock_ff    <= nxt_sock;
            rdata_ff   <= nxt_rdata;
        end
    end
    assign o_rdata = rdata_ff;

    // pin logic, registered so pins come from flip-flops
    logic       ring_indicate_output_ff;
    logic       nxt_ring_indicate_output;
    logic       mf2_ff;
    logic       nxt_mf2;
    logic       mf4_ff;
    logic       nxt_mf4;
    logic       aud_ff;
    logic       nxt_aud;
    logic       spk_ff;
    logic       nxt_spk;
    logic       spk_oe_ff;
    logic       nxt_spk_oe;
    logic [1:0] hiz_ff;
    logic [1:0] nxt_hiz;
    logic       sel0_ff;
    logic       nxt_sel0;
    logic       sel1_ff;
    logic       nxt_sel1;
    logic       both_video;
    assign both_video = sock_ff[0].video_en && sock_ff[1].video_en;

    always_comb
    begin
        nxt_ring_indicate_output = ring_en_ff && !i_ring_pin_mux_select && i_ring_indicate; // RULE10
        nxt_mf2    = ring_en_ff && i_multifunction_terminal_two_is_ring && i_ring_indicate; // RULE10
        nxt_mf4    = ring_en_ff && i_multifunction_terminal_four_is_ring && i_ring_indicate; // RULE10
        nxt_aud    = sock_ff[0].audio_en ? i_card_audio_signal[0] : // RULE14
                     (sock_ff[1].audio_en && i_card_audio_signal[1]);
        nxt_spk    = (sock_ff[0].card_speaker_signal_en && i_card_speaker_signal[0]) ^ // RULE15
                     (sock_ff[1].card_speaker_signal_en && i_card_speaker_signal[1]);
        nxt_spk_oe = sock_ff[0].card_speaker_signal_en || sock_ff[1].card_speaker_signal_en; // RULE16
        nxt_hiz    = {sock_ff[1].video_en, sock_ff[0].video_en}; // RULE11
        // priority select only matters with both sockets in video mode
        nxt_sel0   = sock_ff[0].video_en && !(both_video && sock_ff[0].port_sel); // RULE12
        nxt_sel1   = sock_ff[1].video_en && !(both_video && !sock_ff[0].port_sel); // RULE12
    end

    always_ff @(posedge i_clock)
    begin
        if (i_reset)
        begin
            ring_indicate_output_ff <= 1'b0;
            mf2_ff    <= 1'b0;
            mf4_ff    <= 1'b0;
            aud_ff    <= 1'b0;
            spk_ff    <= 1'b0;
            spk_oe_ff <= 1'b0;
            hiz_ff    <= 2'b00;
            sel0_ff   <= 1'b0;
            sel1_ff   <= 1'b0;
        end
        else
        begin
            ring_indicate_output_ff <= nxt_ring_indicate_output;
            mf2_ff    <= nxt_mf2;
            mf4_ff    <= nxt_mf4;
            aud_ff    <= nxt_aud;
            spk_ff    <= nxt_spk;
            spk_oe_ff <= nxt_spk_oe;
            hiz_ff    <= nxt_hiz;
            sel0_ff   <= nxt_sel0;
            sel1_ff   <= nxt_sel1;
        end
    end
    assign o_ring_indicate_output        = ring_indicate_output_ff;
    assign o_multifunction_terminal_two  = mf2_ff;
    assign o_multifunction_terminal_four = mf4_ff;
    assign o_audio_output_route_code     = aud_ff;
    assign o_speaker_output_pin          = spk_ff;
    assign o_speaker_output_pin_oe       = spk_oe_ff;
    assign o_video_port_hiz              = hiz_ff;
    assign o_video_select_socket0        = sel0_ff;
    assign o_video_select_socket1        = sel1_ff;

    // pin checks look one clock back, since every pin is registered
    a_flag_set_wins : assert property (@(posedge i_clock) disable iff (i_reset) // RULE2
        ev_pri |=> exp_pri_ff)
        else $error("expiry lost");
    a_ring_blocked : assert property (@(posedge i_clock) disable iff (i_reset) // RULE10
        !ring_en_ff |=> !o_ring_indicate_output && !o_multifunction_terminal_two)
        else $error("ring routed while disabled");
    a_speaker_oe : assert property (@(posedge i_clock) disable iff (i_reset) // RULE16
        o_speaker_output_pin_oe == $past(sock_ff[0].card_speaker_signal_en || sock_ff[1].card_speaker_signal_en))
        else $error("speaker drive wrong");
    a_retry_reserved_zero : assert property (@(posedge i_clock) disable iff (i_reset) // RULE8
        $past(rd_hit(i_cfg, `RTCC_OFF_RETRY)) |-> (o_rdata & `RTCC_RETRY_RSVD) == 8'h00)
        else $error("retry reserved bit set");
    a_card_reserved_zero : assert property (@(posedge i_clock) disable iff (i_reset) // RULE13
        $past(rd_hit(i_cfg, `RTCC_OFF_CARD)) |-> (o_rdata & `RTCC_CARD_RSVD) == 8'h00)
        else $error("card reserved bit set");
    a_video_hiz_follow : assert property (@(posedge i_clock) disable iff (i_reset) // RULE11
        o_video_port_hiz == $past({sock_ff[1].video_en, sock_ff[0].video_en}))
        else $error("video float wrong");
    a_audio_socket_wins : assert property (@(posedge i_clock) disable iff (i_reset) // RULE14
        $past(sock_ff[0].audio_en) |-> o_audio_output_route_code == $past(i_card_audio_signal[0]))
        else $error("socket 0 audio not routed");
    a_speaker_xor_mix : assert property (@(posedge i_clock) disable iff (i_reset) // RULE15
        o_speaker_output_pin == $past((sock_ff[0].card_speaker_signal_en && i_card_speaker_signal[0]) ^
                                      (sock_ff[1].card_speaker_signal_en && i_card_speaker_signal[1])))
        else $error("speaker mix wrong");
    a_irq_flag_set : assert property (@(posedge i_clock) disable iff (i_reset) // RULE17
        i_card_functional_irq[0] |=> sock_ff[0].irq_flag)
        else $error("interrupt flag not set");
endmodule : rtcc_card_ctrl

// ### hdl/rtcc_map.svh
`ifndef RTCC_MAP_SVH
`define RTCC_MAP_SVH
`define RTCC_OFF_RETRY      8'h90
`define RTCC_OFF_CARD       8'h91
`define RTCC_RETRY_RESET    8'hc0
`define RTCC_CARD_RESET     8'h00
`define RTCC_BIT_PRI_EN     7
`define RTCC_BIT_CB_EN      6
`define RTCC_BIT_EXP_B      5
`define RTCC_BIT_EXP_A      3
`define RTCC_BIT_EXP_PRI    1
`define RTCC_BIT_RING_EN    7
`define RTCC_BIT_VIDEO_EN   6
`define RTCC_BIT_PORT_SEL   5
`define RTCC_BIT_AUDIO_EN   2
`define RTCC_BIT_CARD_SPEAKER_SIGNAL_EN    1
`define RTCC_BIT_IRQ_FLAG   0
`define RTCC_TIMEOUT_EXP    15
`define RTCC_TIMER_W        16
`define RTCC_RETRY_RSVD     8'h15
`define RTCC_CARD_RSVD      8'h18
`endif

// ### hdl/rtcc_pkg.sv
package rtcc_pkg;
    // one configuration access as seen at the function decode
    typedef struct packed {
        logic       wr;
        logic       rd;
        logic       func;
        logic [7:0] addr;
        logic [7:0] wdata;
    } rtcc_cfg_s;
    // per-socket card control copy
    typedef struct packed {
        logic video_en;
        logic port_sel;
        logic audio_en;
        logic card_speaker_signal_en;
        logic irq_flag;
    } rtcc_sock_s;
    typedef enum logic [1:0] {
        RTCC_IDLE    = 2'b00,
        RTCC_WAIT    = 2'b01,
        RTCC_EXPIRED = 2'b11
    } rtcc_tmr_e;
endpackage : rtcc_pkg

// ### hdl/rtcc_retry_timer.sv
`timescale 1ns/10ps
`include "rtcc_map.svh"
module rtcc_retry_timer
    import rtcc_pkg::*;
(
    // clock and reset
    input  wire logic i_clock,
    input  wire logic i_reset,
    // control
    input  wire logic i_enable,
    input  wire logic i_retried,
    input  wire logic i_returned,
    // event
    output logic      o_expire
);
    localparam logic [`RTCC_TIMER_W-1:0] LIMIT = `RTCC_TIMER_W'(1 << `RTCC_TIMEOUT_EXP);
    rtcc_tmr_e                 state_ff;
    rtcc_tmr_e                 nxt_state;
    logic [`RTCC_TIMER_W-1:0]  count_ff;
    logic [`RTCC_TIMER_W-1:0]  nxt_count;
    logic                      expire_ff;
    logic                      nxt_expire;

    always_comb
    begin
        nxt_state  = state_ff;
        nxt_count  = count_ff;
        nxt_expire = 1'b0;
        case (state_ff)
            RTCC_IDLE:
            begin
                if (i_retried && i_enable) // RULE19
                begin
                    nxt_state = RTCC_WAIT;
                    nxt_count = '0;
                end
            end
            RTCC_WAIT:
            begin
                // disabling mid-wait abandons the wait; no late flag
                if (!i_enable || i_returned) // RULE19
                    nxt_state = RTCC_IDLE;
                else if (i_retried) // RULE19
                    nxt_count = '0;
                else if (count_ff == LIMIT - 1'b1) // RULE1
                begin
                    nxt_state  = RTCC_EXPIRED;
                    nxt_expire = 1'b1;
                end
                else
                    nxt_count = count_ff + 1'b1;
            end
            RTCC_EXPIRED:
                nxt_state = RTCC_IDLE;
            default:
                nxt_state = RTCC_IDLE;
        endcase
    end

    always_ff @(posedge i_clock)
    begin
        if (i_reset)
        begin
            state_ff  <= RTCC_IDLE;
            count_ff  <= '0;
            expire_ff <= 1'b0;
        end
        else
        begin
            state_ff  <= nxt_state;
            count_ff  <= nxt_count;
            expire_ff <= nxt_expire;
        end
    end
    assign o_expire = expire_ff;

    a_expire_after_wait : assert property (@(posedge i_clock) disable iff (i_reset) // RULE1
        o_expire |-> $past(state_ff) == RTCC_WAIT && $past(count_ff) == LIMIT - 1'b1)
        else $error("expiry without full wait");
endmodule : rtcc_retry_timer

// ### testbench/retry_timeout_and_card_control_bench.sv
`timescale 1ns/10ps
`include "rtcc_map.svh"
module retry_timeout_and_card_control_bench
    import rtcc_pkg::*;
;
    localparam logic [7:0] rg_ret  = `RTCC_OFF_RETRY;
    localparam logic [7:0] rg_card = `RTCC_OFF_CARD;
    logic       i_clock = 1'b0;
    logic       i_reset, i_ring_indicate, i_ring_pin_mux_select, i_multifunction_terminal_two_is_ring, i_multifunction_terminal_four_is_ring;
    rtcc_cfg_s  i_cfg;
    logic [7:0] o_rdata;
    logic       i_primary_retried, i_primary_returned;
    logic [1:0] i_cardbus_retried, i_cardbus_returned;
    logic [1:0] i_card_functional_irq, i_card_speaker_signal, i_card_audio_signal, o_video_port_hiz;
    logic       o_ring_indicate_output, o_multifunction_terminal_two, o_multifunction_terminal_four;
    logic       o_audio_output_route_code, o_speaker_output_pin, o_speaker_output_pin_oe;
    logic       o_video_select_socket0, o_video_select_socket1;
    int         bad_count = 0;
    int         tests_run = 0;
    always #25 i_clock = ~i_clock;
    rtcc_card_ctrl dut (.i_clock, .i_reset, .i_cfg, .o_rdata, .i_primary_retried, .i_primary_returned,
        .i_cardbus_retried, .i_cardbus_returned, .i_card_functional_irq, .i_card_speaker_signal,
        .i_card_audio_signal, .i_ring_indicate, .i_ring_pin_mux_select, .i_multifunction_terminal_two_is_ring, .i_multifunction_terminal_four_is_ring,
        .o_ring_indicate_output, .o_multifunction_terminal_two, .o_multifunction_terminal_four,
        .o_audio_output_route_code, .o_speaker_output_pin, .o_speaker_output_pin_oe, .o_video_port_hiz,
        .o_video_select_socket0, .o_video_select_socket1);
    rtcc_master_model master (.i_clock, .o_primary_retried(i_primary_retried),
        .o_primary_returned(i_primary_returned), .o_cardbus_retried(i_cardbus_retried),
        .o_cardbus_returned(i_cardbus_returned));
    task automatic check(input string name, input logic [7:0] exp, input logic [7:0] got);
        tests_run++;
        if (got !== exp)
        begin
            bad_count++;
            $display("ERROR %s expected %h seen %h", name, exp, got);
        end
    endtask : check
    task automatic cfg_wr(input logic f, input logic [7:0] a, input logic [7:0] d);
        @(negedge i_clock);
        i_cfg = '{wr: 1'b1, rd: 1'b0, func: f, addr: a, wdata: d};
        @(negedge i_clock);
        i_cfg = '0;
    endtask : cfg_wr
    // read data is registered, so it is looked at one falling edge after the strobe
    task automatic cfg_rd(input logic f, input logic [7:0] a, input logic [7:0] e);
        @(negedge i_clock);
        i_cfg = '{wr: 1'b0, rd: 1'b1, func: f, addr: a, wdata: 8'h00};
        @(negedge i_clock);
        i_cfg = '0;
        check("rdata", e, o_rdata);
    endtask : cfg_rd
    // outputs are registered; three edges cover input to pin
    task automatic settle();
        repeat (3) @(negedge i_clock);
    endtask : settle
    task automatic wrap_up();
        if (bad_count == 0 && tests_run > 0)
            $display("DONE - PASS");
        else
            $display("DONE - FAIL");
        $finish;
    endtask : wrap_up
    initial
    begin
        repeat (90000) @(posedge i_clock);
        bad_count++;
        wrap_up();
    end
    initial
    begin
        i_reset = 1'b1;
        i_cfg = '0;
        {i_ring_indicate, i_ring_pin_mux_select, i_multifunction_terminal_two_is_ring, i_multifunction_terminal_four_is_ring} = 4'h0;
        {i_card_functional_irq, i_card_speaker_signal, i_card_audio_signal} = 6'h00;
        repeat (20) @(negedge i_clock);
        i_reset = 1'b0;
        cfg_rd(1'b0, rg_ret, 8'hc0);
        cfg_rd(1'b1, rg_card, 8'h00);
        cfg_rd(1'b0, 8'h94, 8'h00);
        cfg_wr(1'b0, rg_card, 8'hff);
        cfg_wr(1'b1, rg_card, 8'h7f);
        cfg_rd(1'b0, rg_card, 8'he6);
        cfg_rd(1'b1, rg_card, 8'he6);
        {i_ring_indicate, i_multifunction_terminal_two_is_ring, i_card_audio_signal, i_card_speaker_signal} = 6'h35;
        settle();
        check("ring_out", 8'h01, {7'h0, o_ring_indicate_output});
        check("mfunc", 8'h02, {6'h0, o_multifunction_terminal_two, o_multifunction_terminal_four});
        check("video_hiz", 8'h03, {6'h0, o_video_port_hiz});
        check("video_sel", 8'h01, {6'h0, o_video_select_socket0, o_video_select_socket1});
        check("audio", 8'h01, {7'h0, o_audio_output_route_code});
        check("speaker", 8'h03, {6'h0, o_speaker_output_pin, o_speaker_output_pin_oe});
        {i_ring_pin_mux_select, i_card_audio_signal, i_card_speaker_signal} = 5'h1b;
        {i_multifunction_terminal_two_is_ring, i_multifunction_terminal_four_is_ring} = 2'b01;
        cfg_wr(1'b0, rg_card, 8'hc6);
        settle();
        check("audio", 8'h00, {7'h0, o_audio_output_route_code});
        check("speaker", 8'h01, {6'h0, o_speaker_output_pin, o_speaker_output_pin_oe});
        check("ring_out", 8'h00, {7'h0, o_ring_indicate_output});
        check("mfunc", 8'h01, {6'h0, o_multifunction_terminal_two, o_multifunction_terminal_four});
        check("video_sel", 8'h02, {6'h0, o_video_select_socket0, o_video_select_socket1});
        {i_ring_pin_mux_select, i_card_functional_irq} = 3'h1;
        settle();
        i_card_functional_irq = 2'h0;
        cfg_rd(1'b0, rg_card, 8'hc7);
        cfg_rd(1'b1, rg_card, 8'he6);
        cfg_wr(1'b0, rg_card, 8'h00);
        cfg_rd(1'b0, rg_card, 8'h01);
        cfg_wr(1'b0, rg_card, 8'h01);
        cfg_rd(1'b0, rg_card, 8'h00);
        cfg_wr(1'b1, rg_card, 8'h00);
        settle();
        check("speaker", 8'h00, {6'h0, o_speaker_output_pin, o_speaker_output_pin_oe});
        check("ring_mfunc", 8'h00, {7'h0, o_ring_indicate_output | o_multifunction_terminal_two |
            o_multifunction_terminal_four});
        // all three masters retried, target a comes back early
        master.retry(3'b111);
        repeat (1000) @(negedge i_clock);
        master.come_back(3'b001);
        repeat (31668) @(negedge i_clock);
        cfg_rd(1'b0, rg_ret, 8'hc0);
        repeat (1200) @(negedge i_clock);
        cfg_rd(1'b0, rg_ret, 8'he2);
        cfg_wr(1'b0, rg_ret, 8'hc0);
        cfg_rd(1'b0, rg_ret, 8'he2);
        cfg_wr(1'b1, rg_ret, 8'h3f);
        cfg_rd(1'b0, rg_ret, 8'he2);
        cfg_wr(1'b0, rg_ret, 8'hea);
        cfg_rd(1'b0, rg_ret, 8'hc0);
        // primary counter switched off, card-bus counter left on
        cfg_wr(1'b0, rg_ret, 8'h40);
        master.retry(3'b111);
        repeat (1000) @(negedge i_clock);
        // target b retried again, so its wait starts over
        master.retry(3'b010);
        repeat (31900) @(negedge i_clock);
        cfg_rd(1'b0, rg_ret, 8'h48);
        repeat (1000) @(negedge i_clock);
        cfg_rd(1'b0, rg_ret, 8'h68);
        wrap_up();
    end
endmodule : retry_timeout_and_card_control_bench

// ### testbench/rtcc_master_model.sv
`timescale 1ns/10ps
module rtcc_master_model
(
    // clock
    input  wire logic  i_clock,
    // retry events towards the bridge, mask order {primary, target b, target a}
    output logic       o_primary_retried,
    output logic       o_primary_returned,
    output logic [1:0] o_cardbus_retried,
    output logic [1:0] o_cardbus_returned
);
    initial
    begin
        {o_primary_retried, o_cardbus_retried}   = 3'h0;
        {o_primary_returned, o_cardbus_returned} = 3'h0;
    end
    // one-cycle pulses off the falling edge; a master that never returns is simply never told to
    task automatic retry(input logic [2:0] mask);
        @(negedge i_clock);
        {o_primary_retried, o_cardbus_retried} = mask;
        @(negedge i_clock);
        {o_primary_retried, o_cardbus_retried} = 3'h0;
    endtask : retry
    task automatic come_back(input logic [2:0] mask);
        @(negedge i_clock);
        {o_primary_returned, o_cardbus_returned} = mask;
        @(negedge i_clock);
        {o_primary_returned, o_cardbus_returned} = 3'h0;
    endtask : come_back
endmodule : rtcc_master_model
